/* hw/video_sync_standard_detect.sv */
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - reset returns all registers to reset values, port idle
// - after hardware or software reset all output pins float
// - luma output never goes below 16
// - line sync follows input, free-runs at line rate without source
// - line sync start and end are 10-bit resampler step positions
// - accumulate low time per line; assert field sync past threshold
// - field sync stays asserted at least one full line
// - parity changes with field sync: 0 odd, 1 even
// - parity keeps alternating when vertical sync is lost
// - after 337 lines plus 3 without vsync declare loss, reacquire
// - field sync lasts 6.5 lines at field rate, runs without video
// - 16-bit chroma ratio in register pair, reset value 0x87C1
// - lock set within four pixels of edge, cleared outside
// - field longer than 285 lines means a PAL source
// - nominal field is 262.5 lines NTSC, 312.5 lines PAL
// - line count swings up to 8 percent raise no mismatch
// - mismatch flag after 2 field periods with wrong line count
// - ratio write or reset clears mismatch, unless one is flagged in the same cycle, and restarts checking
// - reset, standard change or ratio write enter acquisition until lock
module video_sync_standard_detect (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic [7:0] pixIn,
    input wire logic pixValid,
    output logic [7:0] yOut,
    output logic hsyncN,
    output logic vsyncN,
    output logic fieldOut,
    output logic pinOe,
    output logic [15:0] chromaRatio,
    output logic lineLocked,
    output logic acquire,
    output logic stdError
);
    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        return a == b;
    endfunction : hit

    function automatic logic outside(input logic [9:0] v,
                                     input logic [9:0] lo,
                                     input logic [9:0] hi);
        return (v < lo) || (v > hi);
    endfunction : outside

    // register group
    video_sync_pkg::cfg_t cfg_q, cfg_d;
    logic [9:0] hsStart_q, hsStart_d, hsEnd_q, hsEnd_d;
    logic [15:0] ratio_q, ratio_d;
    logic [7:0] vdet_q, vdet_d;
    logic swRst_q, swRst_d;
    logic [15:0] rdata_q, rdata_d;
    logic ratioWr, stdChange;

    // sync group
    logic lowPrev_q, lowPrev_d;
    logic [9:0] lowCnt_q, lowCnt_d;
    video_sync_pkg::vs_state_t vsState_q, vsState_d;
    logic [3:0] vsHalf_q, vsHalf_d;
    logic field_q, field_d;
    logic [9:0] hlCnt_q, hlCnt_d, flyCnt_q, flyCnt_d;
    logic vsLost_q, vsLost_d, acq_q, acq_d;

    // standard check group
    logic skip_q, skip_d, stdErr_q, stdErr_d, srcPal_q, srcPal_d;
    logic [1:0] mis_q, mis_d;
    logic [9:0] lastHl_q, lastHl_d;
    logic errSet, bad;

    // output group
    logic [7:0] yOut_q, yOut_d;
    logic hsyncN_q, hsyncN_d, vsyncN_q, vsyncN_d, field2_q, field2_d;
    logic pinOe_q, pinOe_d, lock2_q, lock2_d;

    logic sampleLow, hEdge, realVs, flyVs, vsStart, lostEvt, restartLoop;
    logic [9:0] pixCnt, nominal;
    logic lineTick, halfTick, locked;
    video_sync_pkg::status_t status;

    sync_line_loop u_loop (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .step(pixValid),
        .hEdge(hEdge),
        .restart(restartLoop),
        .pixCnt(pixCnt),
        .lineTick(lineTick),
        .halfTick(halfTick),
        .locked(locked)
    );

    assign ratioWr = regWr && (hit(regAddr, video_sync_pkg::ADDR_RATIO_LO)
        || hit(regAddr, video_sync_pkg::ADDR_RATIO_HI));
    assign stdChange = regWr && hit(regAddr, video_sync_pkg::ADDR_CTRL)
        && (regWdata[video_sync_pkg::CTRL_PAL_BIT] != cfg_q.stdPal);
    assign status = '{acquire: acq_q, vsLost: vsLost_q, stdErr: stdErr_q,
                      srcPal: srcPal_q, field: field_q, locked: locked};

    always_comb begin
        cfg_d = cfg_q;
        hsStart_d = hsStart_q;
        hsEnd_d = hsEnd_q;
        ratio_d = ratio_q;
        vdet_d = vdet_q;
        swRst_d = 1'b0;
        rdata_d = '0;
        if (swRst_q) begin
            cfg_d = '0;
            hsStart_d = video_sync_pkg::HS_START_RST;
            hsEnd_d = video_sync_pkg::HS_END_RST;
            ratio_d = video_sync_pkg::RATIO_RST;
            vdet_d = video_sync_pkg::VDET_RST;
        end else if (regWr) begin
            case (regAddr)
                video_sync_pkg::ADDR_CTRL: begin
                    cfg_d.stdPal = regWdata[video_sync_pkg::CTRL_PAL_BIT];
                    cfg_d.outEn = regWdata[video_sync_pkg::CTRL_OE_BIT];
                    swRst_d = regWdata[video_sync_pkg::CTRL_SWRST_BIT];
                end
                video_sync_pkg::ADDR_HS_START: hsStart_d = regWdata[9:0];
                video_sync_pkg::ADDR_HS_END: hsEnd_d = regWdata[9:0];
                video_sync_pkg::ADDR_RATIO_LO: ratio_d[7:0] = regWdata[7:0];
                video_sync_pkg::ADDR_RATIO_HI: ratio_d[15:8] = regWdata[7:0];
                video_sync_pkg::ADDR_VDET: vdet_d = regWdata[7:0];
                default: ;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                video_sync_pkg::ADDR_CTRL: rdata_d = {14'h0000, cfg_q};
                video_sync_pkg::ADDR_HS_START: rdata_d = {6'h00, hsStart_q};
                video_sync_pkg::ADDR_HS_END: rdata_d = {6'h00, hsEnd_q};
                video_sync_pkg::ADDR_RATIO_LO: rdata_d = {8'h00, ratio_q[7:0]};
                video_sync_pkg::ADDR_RATIO_HI: rdata_d = {8'h00, ratio_q[15:8]};
                video_sync_pkg::ADDR_VDET: rdata_d = {8'h00, vdet_q};
                video_sync_pkg::ADDR_STATUS: rdata_d = {10'h000, status};
                video_sync_pkg::ADDR_FIELD_LINES: rdata_d = {6'h00, lastHl_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= '0;
            hsStart_q <= video_sync_pkg::HS_START_RST;
            hsEnd_q <= video_sync_pkg::HS_END_RST;
            ratio_q <= video_sync_pkg::RATIO_RST;
            vdet_q <= video_sync_pkg::VDET_RST;
            swRst_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            hsStart_q <= hsStart_d;
            hsEnd_q <= hsEnd_d;
            ratio_q <= ratio_d;
            vdet_q <= vdet_d;
            swRst_q <= swRst_d;
            rdata_q <= rdata_d;
        end
    end

    // converter samples share clk_sys, so no synchroniser is needed
    assign sampleLow = pixValid && (pixIn < video_sync_pkg::SYNC_LEVEL);
    assign hEdge = sampleLow && !lowPrev_q;
    assign nominal = cfg_q.stdPal ? video_sync_pkg::HL_PAL
                                  : video_sync_pkg::HL_NTSC;
    assign realVs = (vsState_q == video_sync_pkg::VS_WAIT)
        && (lowCnt_q > {2'h0, vdet_q});
    // flywheel keeps fields coming with no video
    assign flyVs = (vsState_q == video_sync_pkg::VS_WAIT) && vsLost_q
        && (flyCnt_q >= nominal);
    assign vsStart = realVs || flyVs;
    assign lostEvt = !vsLost_q && !realVs
        && (hlCnt_q == video_sync_pkg::HL_LOST);
    assign restartLoop = lostEvt || swRst_q;

    always_comb begin
        lowPrev_d = pixValid ? sampleLow : lowPrev_q;
        lowCnt_d = lowCnt_q;
        if (hEdge || lineTick) begin
            lowCnt_d = {9'h000, sampleLow};
        end else if (sampleLow && lowCnt_q != 10'h3FF) begin
            lowCnt_d = lowCnt_q + 10'h001;
        end
        vsState_d = vsState_q;
        vsHalf_d = vsHalf_q;
        field_d = field_q;
        case (vsState_q)
            video_sync_pkg::VS_WAIT: begin
                if (vsStart) begin
                    vsState_d = video_sync_pkg::VS_PULSE;
                    vsHalf_d = '0;
                    field_d = ~field_q;
                end
            end
            video_sync_pkg::VS_PULSE: begin
                // 13 half lines, well over the one-line minimum
                if (halfTick) begin
                    vsHalf_d = vsHalf_q + 4'h1;
                    if (vsHalf_q == video_sync_pkg::VS_HALF_LINES - 4'h1) begin
                        vsState_d = video_sync_pkg::VS_WAIT;
                    end
                end
            end
            default: vsState_d = video_sync_pkg::VS_WAIT;
        endcase
        hlCnt_d = hlCnt_q;
        if (realVs) begin
            hlCnt_d = '0;
        end else if (halfTick && hlCnt_q != 10'h3FF) begin
            hlCnt_d = hlCnt_q + 10'h001;
        end
        flyCnt_d = flyCnt_q;
        if (vsStart) begin
            flyCnt_d = '0;
        end else if (halfTick && flyCnt_q != 10'h3FF) begin
            flyCnt_d = flyCnt_q + 10'h001;
        end
        vsLost_d = vsLost_q;
        if (lostEvt) begin
            vsLost_d = 1'b1;
        end else if (realVs) begin
            vsLost_d = 1'b0;
        end
        acq_d = acq_q;
        if (lostEvt || ratioWr || stdChange || swRst_q) begin
            acq_d = 1'b1;
        end else if (locked) begin
            acq_d = 1'b0;
        end
        if (swRst_q) begin
            vsState_d = video_sync_pkg::VS_WAIT;
            field_d = 1'b0;
            hlCnt_d = '0;
            flyCnt_d = '0;
            vsLost_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lowPrev_q <= 1'b0;
            lowCnt_q <= '0;
            vsState_q <= video_sync_pkg::VS_WAIT;
            vsHalf_q <= '0;
            field_q <= 1'b0;
            hlCnt_q <= '0;
            flyCnt_q <= '0;
            vsLost_q <= 1'b0;
            acq_q <= 1'b1;
        end else begin
            lowPrev_q <= lowPrev_d;
            lowCnt_q <= lowCnt_d;
            vsState_q <= vsState_d;
            vsHalf_q <= vsHalf_d;
            field_q <= field_d;
            hlCnt_q <= hlCnt_d;
            flyCnt_q <= flyCnt_d;
            vsLost_q <= vsLost_d;
            acq_q <= acq_d;
        end
    end

    // field lengths are judged in half lines so 262.5 and 312.5 are exact
    assign bad = cfg_q.stdPal
        ? outside(hlCnt_q, video_sync_pkg::PAL_MIN, video_sync_pkg::PAL_MAX)
        : outside(hlCnt_q, video_sync_pkg::NTSC_MIN,
                  video_sync_pkg::NTSC_MAX);
    assign errSet = realVs && !skip_q && bad
        && (mis_q == video_sync_pkg::MISMATCH_FIELDS - 2'h1);

    always_comb begin
        skip_d = skip_q;
        mis_d = mis_q;
        srcPal_d = srcPal_q;
        lastHl_d = lastHl_q;
        stdErr_d = stdErr_q;
        if (realVs) begin
            lastHl_d = hlCnt_q;
            srcPal_d = hlCnt_q > video_sync_pkg::HL_PAL_THRESH;
            if (skip_q) begin
                // first field after a restart is partial
                skip_d = 1'b0;
            end else if (bad) begin
                mis_d = (mis_q == video_sync_pkg::MISMATCH_FIELDS) ? mis_q
                                                                   : mis_q + 2'h1;
            end else begin
                mis_d = '0;
            end
        end
        if (ratioWr || swRst_q) begin
            mis_d = '0;
            skip_d = 1'b1;
            stdErr_d = 1'b0;
        end
        if (errSet) begin
            stdErr_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            skip_q <= 1'b1;
            mis_q <= '0;
            srcPal_q <= 1'b0;
            lastHl_q <= '0;
            stdErr_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
            mis_q <= mis_d;
            srcPal_q <= srcPal_d;
            lastHl_q <= lastHl_d;
            stdErr_q <= stdErr_d;
        end
    end

    always_comb begin
        yOut_d = yOut_q;
        if (pixValid) begin
            yOut_d = (pixIn < video_sync_pkg::Y_MIN) ? video_sync_pkg::Y_MIN
                                                     : pixIn;
        end
        hsyncN_d = !((pixCnt >= hsStart_q) && (pixCnt < hsEnd_q));
        vsyncN_d = (vsState_d != video_sync_pkg::VS_PULSE);
        field2_d = field_d;
        pinOe_d = cfg_q.outEn && !swRst_q;
        lock2_d = locked;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            yOut_q <= video_sync_pkg::Y_MIN;
            hsyncN_q <= 1'b1;
            vsyncN_q <= 1'b1;
            field2_q <= 1'b0;
            pinOe_q <= 1'b0;
            lock2_q <= 1'b0;
        end else begin
            yOut_q <= yOut_d;
            hsyncN_q <= hsyncN_d;
            vsyncN_q <= vsyncN_d;
            field2_q <= field2_d;
            pinOe_q <= pinOe_d;
            lock2_q <= lock2_d;
        end
    end

    assign regRdata = rdata_q;
    assign yOut = yOut_q;
    assign hsyncN = hsyncN_q;
    assign vsyncN = vsyncN_q;
    assign fieldOut = field2_q;
    assign pinOe = pinOe_q;
    assign chromaRatio = ratio_q;
    assign lineLocked = lock2_q;
    assign acquire = acq_q;
    assign stdError = stdErr_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_vsFall;
        $fell(vsyncN);
    endsequence

    a_luma_floor: assert property (yOut >= video_sync_pkg::Y_MIN)
        else $error("luma below floor");
    a_vs_length: assert property ($rose(vsyncN) |->
        $past(vsHalf_q) == video_sync_pkg::VS_HALF_LINES - 4'h1)
        else $error("field sync ended early");
    a_field_with_vs: assert property ($changed(fieldOut) |-> s_vsFall)
        else $error("parity moved without field sync");
    a_field_toggles: assert property (s_vsFall |-> $changed(fieldOut))
        else $error("parity did not alternate");
    a_lost_declare: assert property (lostEvt |=> vsLost_q && acq_q)
        else $error("loss not declared");
    a_lock_drop: assert property (hEdge && pixValid && !restartLoop
        && pixCnt > video_sync_pkg::LOCK_WIN
        && pixCnt < video_sync_pkg::LINE_STEPS - video_sync_pkg::LOCK_WIN
        |=> ##1 !lineLocked)
        else $error("lock kept outside window");
    a_ratio_clear: assert property (ratioWr && !errSet |=> !stdError)
        else $error("mismatch flag not cleared");
    a_err_two: assert property ($rose(stdError) |->
        $past(realVs) && $past(mis_q) == 2'h1)
        else $error("mismatch raised too soon");
    a_hsync_window: assert property (!hsyncN |->
        $past(pixCnt >= hsStart_q && pixCnt < hsEnd_q))
        else $error("line sync outside window");
    a_oe_reset: assert property (swRst_q |=> !pinOe)
        else $error("pins driven after soft reset");
endmodule : video_sync_standard_detect
`default_nettype wire

/* hw/video_sync_pkg.sv */
package video_sync_pkg;
    // register map, 16-bit data, one word per address
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_HS_START = 4'h1;
    localparam logic [3:0] ADDR_HS_END = 4'h2;
    localparam logic [3:0] ADDR_RATIO_LO = 4'h3;
    localparam logic [3:0] ADDR_RATIO_HI = 4'h4;
    localparam logic [3:0] ADDR_VDET = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_FIELD_LINES = 4'h7;

    // control register fields
    localparam int CTRL_PAL_BIT = 0;
    localparam int CTRL_OE_BIT = 1;
    localparam int CTRL_SWRST_BIT = 7;

    // reset values
    localparam logic [15:0] RATIO_RST = 16'h87C1;
    localparam logic [9:0] HS_START_RST = 10'h000;
    localparam logic [9:0] HS_END_RST = 10'h040;
    localparam logic [7:0] VDET_RST = 8'hC0;

    // sample levels
    localparam logic [7:0] Y_MIN = 8'h10;
    localparam logic [7:0] SYNC_LEVEL = 8'h08;

    // line timing in resampler steps
    localparam logic [9:0] LINE_STEPS = 10'h35A;
    localparam logic [9:0] HALF_STEPS = 10'h1AD;
    localparam logic [9:0] LOCK_WIN = 10'h004;

    // field timing in half lines
    localparam logic [3:0] VS_HALF_LINES = 4'hD;
    localparam int HL_NTSC_INT = 525;
    localparam int HL_PAL_INT = 625;
    localparam logic [9:0] HL_NTSC = 10'h20D;
    localparam logic [9:0] HL_PAL = 10'h271;
    localparam logic [9:0] HL_PAL_THRESH = 10'h23A;
    localparam logic [9:0] HL_LOST = 10'h2A8;
    localparam logic [9:0] NTSC_MIN = 10'(HL_NTSC_INT - HL_NTSC_INT * 8 / 100);
    localparam logic [9:0] NTSC_MAX = 10'(HL_NTSC_INT + HL_NTSC_INT * 8 / 100);
    localparam logic [9:0] PAL_MIN = 10'(HL_PAL_INT - HL_PAL_INT * 8 / 100);
    localparam logic [9:0] PAL_MAX = 10'(HL_PAL_INT + HL_PAL_INT * 8 / 100);
    localparam logic [1:0] MISMATCH_FIELDS = 2'h2;

    typedef enum logic {
        VS_WAIT = 1'b0,
        VS_PULSE = 1'b1
    } vs_state_t;

    typedef struct packed {
        logic outEn;
        logic stdPal;
    } cfg_t;

    // status word, bit 0 is locked
    typedef struct packed {
        logic acquire;
        logic vsLost;
        logic stdErr;
        logic srcPal;
        logic field;
        logic locked;
    } status_t;
endpackage : video_sync_pkg

/* hw/sync_line_loop.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_line_loop (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic step,
    input wire logic hEdge,
    input wire logic restart,
    output logic [9:0] pixCnt,
    output logic lineTick,
    output logic halfTick,
    output logic locked
);
    logic [9:0] cnt_q, cnt_d;
    logic line_q, line_d, half_q, half_d, lock_q, lock_d;
    logic inWin;

    always_comb begin
        inWin = (cnt_q <= video_sync_pkg::LOCK_WIN)
            || (cnt_q >= video_sync_pkg::LINE_STEPS - video_sync_pkg::LOCK_WIN);
        cnt_d = cnt_q;
        lock_d = lock_q;
        line_d = 1'b0;
        half_d = 1'b0;
        if (restart) begin
            cnt_d = '0;
            lock_d = 1'b0;
        end else if (step) begin
            // free-runs at line rate with no source
            line_d = (cnt_q == video_sync_pkg::LINE_STEPS - 10'h001);
            cnt_d = line_d ? '0 : cnt_q + 10'h001;
            half_d = line_d || (cnt_q == video_sync_pkg::HALF_STEPS - 10'h001);
            if (hEdge) begin
                lock_d = inWin;
                if (!inWin) begin
                    // snap to the edge: line restarts here
                    cnt_d = '0;
                    line_d = 1'b1;
                    half_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            line_q <= 1'b0;
            half_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            line_q <= line_d;
            half_q <= half_d;
            lock_q <= lock_d;
        end
    end

    assign pixCnt = cnt_q;
    assign lineTick = line_q;
    assign halfTick = half_q;
    assign locked = lock_q;
endmodule : sync_line_loop
`default_nettype wire

/* test/video_source.sv */
`timescale 1ns/1ps
`default_nettype none
module video_source (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic srcOn,
    input wire logic vsReq,
    input wire logic [7:0] luma,
    input wire logic [9:0] lineLen,
    output logic [7:0] pixIn,
    output logic pixValid,
    output logic [9:0] pos
);
    logic tip;
    // one sample per clock; no source means a flat level with no sync edges
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pos <= 10'h000;
        end else if (pos >= lineLen - 10'h001) begin
            pos <= 10'h000;
        end else begin
            pos <= pos + 10'h001;
        end
    end
    always_comb begin
        pixValid = nrst;
        tip = (pos < 10'h040) || (vsReq && pos < 10'h190);
        pixIn = !srcOn ? 8'h80 : (tip ? 8'h00 : luma);
    end
endmodule : video_source
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic srcOn = 1'b0;
    logic vsReq = 1'b0;
    logic [7:0] luma = 8'h40;
    logic [9:0] lineLen = 10'h35A;
    wire logic [15:0] regRdata, chromaRatio;
    wire logic [7:0] yOut, pixIn;
    wire logic [9:0] pos;
    wire logic hsyncN, vsyncN, fieldOut, pinOe, lineLocked, acquire;
    wire logic stdError, pixValid;
    int n_errors = 0;
    int n_compared = 0;
    int a, b, w;
    always #10 clk_sys = ~clk_sys;
    video_sync_standard_detect video_sync_standard_detect_i (.clk_sys(clk_sys),
        .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .pixIn(pixIn), .pixValid(pixValid),
        .yOut(yOut), .hsyncN(hsyncN), .vsyncN(vsyncN), .fieldOut(fieldOut),
        .pinOe(pinOe), .chromaRatio(chromaRatio), .lineLocked(lineLocked),
        .acquire(acquire), .stdError(stdError));
    video_source video_source_i (.clk_sys(clk_sys), .nrst(nrst),
        .srcOn(srcOn), .vsReq(vsReq), .luma(luma), .lineLen(lineLen),
        .pixIn(pixIn), .pixValid(pixValid), .pos(pos));
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= ad;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
        #1;
    endtask : wr
    task automatic rdc(input string what, input logic [3:0] ad,
                       input logic [15:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        check(what, regRdata, exp);
    endtask : rdc
    task automatic waitPos(input logic [9:0] p);
        do begin
            @(posedge clk_sys);
            #1;
        end while (pos !== p);
    endtask : waitPos
    // cycles until the chosen sync output reaches lvl, bounded
    task automatic edgeWait(input bit v, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while ((v ? vsyncN : hsyncN) !== lvl && n < 20000);
    endtask : edgeWait
    task automatic doVs(input logic expField);
        logic f;
        int n;
        waitPos(10'h1F4);
        vsReq <= 1'b1;
        n = 0;
        do begin
            f = fieldOut;
            @(posedge clk_sys);
            #1;
            n++;
        end while (vsyncN !== 1'b0 && n < 2000);
        vsReq <= 1'b0;
        check("fieldBefore", {15'h0000, f}, {15'h0000, ~expField});
        check("fieldOut", {15'h0000, fieldOut}, {15'h0000, expField});
        edgeWait(1'b1, 1'b1, n);
        check("vsMinLine", 16'(n >= 858), 16'h0001);
        check("vsWidth", 16'(n > 12*429 && n <= 13*429), 16'h0001);
    endtask : doVs
    task automatic complete_run;
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        #1800000;
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        check("pinOe", {15'h0000, pinOe}, 16'h0000);
        check("ratio", chromaRatio, 16'h87C1);
        check("yOut", {8'h00, yOut}, 16'h0010);
        check("flags", {11'h000, vsyncN, fieldOut, lineLocked, acquire,
              stdError}, 16'h0012);
        @(posedge clk_sys);
        nrst <= 1'b1;
        rdc("vdet", video_sync_pkg::ADDR_VDET, 16'h00C0);
        rdc("hsEnd", video_sync_pkg::ADDR_HS_END, 16'h0040);
        rdc("unmapped", 4'h9, 16'h0000);
        wr(video_sync_pkg::ADDR_RATIO_LO, 16'h0026);
        wr(video_sync_pkg::ADDR_RATIO_HI, 16'h00A8);
        check("ratio", chromaRatio, 16'hA826);
        wr(video_sync_pkg::ADDR_CTRL, 16'h0002);
        // pin enable is one register stage behind the control bit
        @(posedge clk_sys);
        #1;
        check("pinOe", {15'h0000, pinOe}, 16'h0001);
        // enable bit kept set so only the soft reset can float the pins
        wr(video_sync_pkg::ADDR_CTRL, 16'h0082);
        repeat (2) @(posedge clk_sys);
        #1;
        check("pinOe", {15'h0000, pinOe}, 16'h0000);
        check("ratio", chromaRatio, 16'h87C1);
        wr(video_sync_pkg::ADDR_CTRL, 16'h0002);
        srcOn <= 1'b1;
        w = 0;
        while (lineLocked !== 1'b1 && w < 12000) begin
            @(posedge clk_sys);
            #1;
            w++;
        end
        check("locked", {15'h0000, lineLocked}, 16'h0001);
        check("acquire", {15'h0000, acquire}, 16'h0000);
        luma <= 8'h0C;
        waitPos(10'h190);
        check("yClamp", {8'h00, yOut}, 16'h0010);
        luma <= 8'hC8;
        waitPos(10'h190);
        check("yPass", {8'h00, yOut}, 16'h00C8);
        wr(video_sync_pkg::ADDR_HS_START, 16'h0064);
        wr(video_sync_pkg::ADDR_HS_END, 16'h00A4);
        edgeWait(1'b0, 1'b1, a);
        edgeWait(1'b0, 1'b0, a);
        edgeWait(1'b0, 1'b1, w);
        check("hsWidth", 16'(w), 16'h0040);
        // edges 12 steps late every line fall outside the lock window
        lineLen <= 10'h366;
        repeat (3) waitPos(10'h258);
        check("lockLost", {15'h0000, lineLocked}, 16'h0000);
        lineLen <= 10'h35A;
        repeat (3) waitPos(10'h258);
        check("relock", {15'h0000, lineLocked}, 16'h0001);
        wr(video_sync_pkg::ADDR_RATIO_LO, 16'h00C1);
        check("acqRatio", {15'h0000, acquire}, 16'h0001);
        check("stdErr", {15'h0000, stdError}, 16'h0000);
        doVs(1'b1);
        doVs(1'b0);
        // third short field in a row: second bad one after the skipped one
        doVs(1'b1);
        check("stdErr", {15'h0000, stdError}, 16'h0001);
        rdc("status", video_sync_pkg::ADDR_STATUS, 16'h000B);
        wr(video_sync_pkg::ADDR_RATIO_HI, 16'h0087);
        check("errClear", {15'h0000, stdError}, 16'h0000);
        check("ratio", chromaRatio, 16'h87C1);
        wr(video_sync_pkg::ADDR_CTRL, 16'h0003);
        check("acqStd", {15'h0000, acquire}, 16'h0001);
        srcOn <= 1'b0;
        edgeWait(1'b0, 1'b1, a);
        edgeWait(1'b0, 1'b0, a);
        edgeWait(1'b0, 1'b1, a);
        edgeWait(1'b0, 1'b0, b);
        check("freeRun", 16'(a + b), 16'h035A);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
